// ### include/lse_params.svh
// constants for the led sequence engine
`ifndef LSE_PARAMS_SVH
`define LSE_PARAMS_SVH
`define LSE_IX_ENABLE 8'h00
`define LSE_IX_CONFIG 8'h08
`define LSE_IX_PC0 8'h09
`define LSE_IX_STATUS 8'h0C
`define LSE_IX_PMEM 8'h10
`define LSE_IX_PMEM_END 8'h6F
`define LSE_LOG_BIT 7
`define LSE_INTCLK_BIT 0
`define LSE_DETEN_BIT 1
`define LSE_EXTUSED_BIT 3
`define LSE_MEM_RST 16'h0000
`define LSE_CLK_HZ 20000000
`define LSE_TB_HZ 32768
`define LSE_TB_DIV (`LSE_CLK_HZ / `LSE_TB_HZ)
`define LSE_FIX_TICKS 16
`define LSE_PRE_FAST 16
`define LSE_PRE_SLOW 512
`define LSE_TOUT_TICKS 3
`define LSE_TIN_TICKS 2
`define LSE_RESP_OK 2'b00
`define LSE_RESP_ERR 2'b10
`endif

// ### include/lse_pkg.sv
// types for the led sequence engine
package lse_pkg;
    typedef enum logic [2:0] {
        LSE_IDLE  = 3'b000,
        LSE_RAMP  = 3'b001,
        LSE_FIX   = 3'b010,
        LSE_TWAIT = 3'b011
    } lse_st_t;

    typedef struct packed {
        lse_st_t          st;
        logic [3:0]       pc;
        logic [7:0]       pwm;
        logic [14:0]      cnt;
        logic [14:0]      per;
        logic [7:0]       left;
        logic [15:0]      ins;
        logic [1:0]       execution_control_field;
        logic [15:0][5:0] lc;
        logic [3:0]       lat;
    } lse_ch_t;

    typedef struct packed {
        lse_ch_t [2:0]          ch;
        logic [2:0][15:0][15:0] mem;
        logic                   log_en;
        logic [1:0]             cfg;
        logic [2:0]             irq;
        logic [9:0]             div;
        logic                   sq;
        logic [1:0]             tin;
        logic [1:0]             tout;
        logic                   awf;
        logic                   wf;
        logic [7:0]             awi;
        logic [31:0]            wd;
        logic [3:0]             ws;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
        logic [2:0][7:0]        pwm_q;
        logic                   int_n;
        logic                   trig_oe;
        logic                   trig_out;
    } lse_state_t;
endpackage : lse_pkg

// ### verilog/lse_engine.sv
// three-channel led program engine with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "lse_params.svh"

module lse_engine #(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // timebase and trigger pins
    input  wire logic              slow_clock_input,
    input  wire logic              trig_in_n,
    output logic                   trig_out,
    output logic                   trig_oe,
    // led and interrupt outputs
    output logic [2:0][7:0]        pwm_out,
    output logic                   int_n
);

    lse_pkg::lse_state_t r;
    lse_pkg::lse_state_t n;

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    function automatic logic [7:0] logmap(input logic [7:0] p);
        logic [15:0] sq;
        sq = 16'({8'h00, p} * {8'h00, p}) + {7'h00, p, 1'b0};
        return sq[15:8];
    endfunction : logmap

    // completion: advance pc unless single-execute, step modes 01 and 11 drop to hold 00
    function automatic lse_pkg::lse_ch_t fin(input lse_pkg::lse_ch_t c,
                                             input logic jump,
                                             input logic [3:0] tgt);
        lse_pkg::lse_ch_t o;
        o = c;
        o.st = lse_pkg::LSE_IDLE;
        if (jump) begin
            o.pc = tgt;
        end else if (c.execution_control_field != 2'b11) begin
            o.pc = c.pc + 4'h1;
        end
        if (c.execution_control_field[0]) begin
            o.execution_control_field = 2'b00;
        end
        return o;
    endfunction : fin

    function automatic logic is_pmem(input logic [7:0] ix);
        return ix >= `LSE_IX_PMEM && ix <= `LSE_IX_PMEM_END;
    endfunction : is_pmem

    function automatic logic is_reg(input logic [7:0] ix);
        return ix == `LSE_IX_ENABLE || ix == `LSE_IX_CONFIG ||
               (ix >= `LSE_IX_PC0 && ix <= `LSE_IX_STATUS) ||
               is_pmem(ix);
    endfunction : is_reg

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic       tick;
        logic       ext_used;
        logic       ext_hit;
        logic [2:0][3:0] snd;
        logic [2:0][3:0] clr;
        logic [3:0] want;
        logic [7:0] ix;
        logic [6:0] rel;
        logic [14:0] pre;
        logic       aw_go;
        logic       w_go;
        logic [1:0] wc;
        n = r;
        tick = 1'b0;
        ext_used = 1'b0;
        ext_hit = 1'b0;
        snd = '0;
        clr = '0;
        want = 4'h0;
        aw_go = 1'b0;
        w_go = 1'b0;
        ix = 8'h00;
        rel = 7'h00;
        pre = 15'h0000;
        wc = 2'b00;

        // timebase select and generation
        ext_used = ~r.cfg[`LSE_INTCLK_BIT] & r.cfg[`LSE_DETEN_BIT];
        n.sq = slow_clock_input;
        if (ext_used) begin
            tick = slow_clock_input & ~r.sq;
        end else begin
            n.div = r.div + 10'h001;
            if (r.div == 10'(`LSE_TB_DIV - 1)) begin
                n.div = 10'h000;
                tick = 1'b1;
            end
        end

        // external trigger pin, own pulses masked
        if (tick) begin
            if (r.tout != 2'b00) begin
                n.tout = r.tout - 2'b01;
            end
            if (!trig_in_n && r.tout == 2'b00) begin
                if (r.tin != 2'(`LSE_TIN_TICKS)) begin
                    n.tin = r.tin + 2'b01;
                    ext_hit = (r.tin == 2'(`LSE_TIN_TICKS - 1));
                end
            end else begin
                n.tin = 2'b00;
            end
        end

        // the three engines
        for (int c = 0; c < 3; c++) begin
            lse_pkg::lse_ch_t e;
            e = r.ch[c];
            if (tick) begin
                case (e.st)
                    lse_pkg::LSE_IDLE: begin
                        if (e.execution_control_field != 2'b00) begin
                            e.ins = r.mem[c][e.pc];
                            e.cnt = 15'(`LSE_FIX_TICKS);
                            e.st = lse_pkg::LSE_FIX;
                            if (!e.ins[15]) begin
                                if (e.ins[13:8] != 6'h00) begin
                                    pre = e.ins[14] ?
                                        15'(`LSE_PRE_SLOW) :
                                        15'(`LSE_PRE_FAST);
                                    e.per = 15'(pre * e.ins[13:8]);
                                    e.cnt = e.per;
                                    e.left = {1'b0, e.ins[6:0]} + 8'h01;
                                    e.st = lse_pkg::LSE_RAMP;
                                end else if (e.ins[14]) begin
                                    e.pwm = e.ins[7:0];
                                end
                            end else if (e.ins[15:13] == 3'b111) begin
                                snd[c] = {e.ins[6], e.ins[3:1]};
                                if (snd[c][3]) begin
                                    n.tout = 2'(`LSE_TOUT_TICKS);
                                end
                            end
                        end
                    end
                    lse_pkg::LSE_RAMP: begin
                        e.cnt = e.cnt - 15'h0001;
                        if (e.cnt == 15'h0000) begin
                            if (e.ins[6:0] != 7'h00) begin
                                if (e.ins[7]) begin
                                    if (e.pwm != 8'h00) begin
                                        e.pwm = e.pwm - 8'h01;
                                    end
                                end else if (e.pwm != 8'hFF) begin
                                    e.pwm = e.pwm + 8'h01;
                                end
                            end
                            e.left = e.left - 8'h01;
                            e.cnt = e.per;
                            if (e.left == 8'h00) begin
                                e = fin(e, 1'b0, 4'h0);
                            end
                        end
                    end
                    lse_pkg::LSE_FIX: begin
                        e.cnt = e.cnt - 15'h0001;
                        if (e.cnt == 15'h0000) begin
                            case (e.ins[15:13])
                                3'b000: begin
                                    if (e.ins[14]) begin
                                        e = fin(e, 1'b0, 4'h0);
                                    end else begin
                                        e = fin(e, 1'b1, 4'h0);
                                    end
                                end
                                3'b101: begin
                                    if (e.ins[12:7] == 6'h00) begin
                                        e = fin(e, 1'b1, e.ins[3:0]);
                                    end else if (e.lc[e.pc] < e.ins[12:7]) begin
                                        e.lc[e.pc] = e.lc[e.pc] + 6'h01;
                                        e = fin(e, 1'b1, e.ins[3:0]);
                                    end else begin
                                        e.lc[e.pc] = 6'h00;
                                        e = fin(e, 1'b0, 4'h0);
                                    end
                                end
                                3'b110: begin
                                    e.st = lse_pkg::LSE_IDLE;
                                    e.pc = 4'h0;
                                    e.execution_control_field = 2'b00;
                                    if (e.ins[12]) begin
                                        n.irq[2-c] = 1'b1;
                                    end
                                    if (e.ins[11]) begin
                                        e.pwm = 8'h00;
                                    end
                                end
                                3'b111: begin
                                    if ({e.ins[12], e.ins[9:7]} != 4'h0) begin
                                        e.st = lse_pkg::LSE_TWAIT;
                                    end else begin
                                        e = fin(e, 1'b0, 4'h0);
                                    end
                                end
                                default: begin
                                    e = fin(e, 1'b0, 4'h0);
                                end
                            endcase
                        end
                    end
                    lse_pkg::LSE_TWAIT: begin
                        want = {e.ins[12], e.ins[9:7]};
                        if ((e.lat & want) == want) begin
                            clr[c] = want;
                            e = fin(e, 1'b0, 4'h0);
                        end
                    end
                    default: begin
                        e.st = lse_pkg::LSE_IDLE;
                    end
                endcase
            end
            n.ch[c] = e;
        end
        // arriving trigger beats a clear in the same cycle
        for (int c = 0; c < 3; c++) begin
            n.ch[c].lat = (r.ch[c].lat & ~clr[c]) |
                          {ext_hit, snd[2][c], snd[1][c], snd[0][c]};
        end

        // axi4-lite write side
        aw_go = awvalid & r.awready;
        w_go = wvalid & r.wready;
        if (aw_go) begin
            n.awf = 1'b1;
            n.awi = awaddr[9:2];
            n.awready = 1'b0;
        end
        if (w_go) begin
            n.wf = 1'b1;
            n.wd = wdata;
            n.ws = wstrb;
            n.wready = 1'b0;
        end
        if (r.awf && r.wf && !r.bvalid) begin
            n.awf = 1'b0;
            n.wf = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = is_reg(r.awi) ? `LSE_RESP_OK : `LSE_RESP_ERR;
            rel = 7'(r.awi - `LSE_IX_PMEM);
            if (r.ws[0]) begin
                if (r.awi == `LSE_IX_ENABLE) begin
                    n.log_en = r.wd[`LSE_LOG_BIT];
                    n.ch[0].execution_control_field = r.wd[5:4];
                    n.ch[1].execution_control_field = r.wd[3:2];
                    n.ch[2].execution_control_field = r.wd[1:0];
                end else if (r.awi == `LSE_IX_CONFIG) begin
                    n.cfg = r.wd[1:0];
                end else if (r.awi >= `LSE_IX_PC0 &&
                             r.awi < `LSE_IX_STATUS) begin
                    wc = 2'(r.awi - `LSE_IX_PC0);
                    if (r.ch[wc].execution_control_field == 2'b00 &&
                        r.ch[wc].st == lse_pkg::LSE_IDLE) begin
                        n.ch[wc].pc = r.wd[3:0];
                    end
                end else if (is_pmem(r.awi)) begin
                    if (rel[0]) begin
                        n.mem[rel[6:5]][rel[4:1]][7:0] = r.wd[7:0];
                    end else begin
                        n.mem[rel[6:5]][rel[4:1]][15:8] = r.wd[7:0];
                    end
                end
            end
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end

        // axi4-lite read side
        if (arvalid && r.arready) begin
            ix = araddr[9:2];
            rel = 7'(ix - `LSE_IX_PMEM);
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = is_reg(ix) ? `LSE_RESP_OK : `LSE_RESP_ERR;
            n.rdata = 32'h0000_0000;
            if (ix == `LSE_IX_ENABLE) begin
                n.rdata[7:0] = {r.log_en, 1'b0, r.ch[0].execution_control_field,
                                r.ch[1].execution_control_field, r.ch[2].execution_control_field};
            end else if (ix == `LSE_IX_CONFIG) begin
                n.rdata[1:0] = r.cfg;
            end else if (ix >= `LSE_IX_PC0 && ix < `LSE_IX_STATUS) begin
                n.rdata[3:0] = r.ch[2'(ix - `LSE_IX_PC0)].pc;
            end else if (ix == `LSE_IX_STATUS) begin
                n.rdata[`LSE_EXTUSED_BIT] = ext_used;
                n.rdata[2:0] = r.irq;
                n.irq = n.irq & ~r.irq;
            end else if (is_pmem(ix)) begin
                n.rdata[7:0] = rel[0] ? r.mem[rel[6:5]][rel[4:1]][7:0] :
                                        r.mem[rel[6:5]][rel[4:1]][15:8];
            end
        end
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end

        // registered outputs
        for (int c = 0; c < 3; c++) begin
            n.pwm_q[c] = n.log_en ? logmap(n.ch[c].pwm) :
                                    n.ch[c].pwm;
        end
        n.int_n = ~|n.irq;
        n.trig_oe = n.tout != 2'b00;
        n.trig_out = 1'b0;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
            r.int_n <= 1'b1;
        end else if (ce) begin
            r <= n;
        end
    end

    assign awready = r.awready;
    assign wready = r.wready;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign arready = r.arready;
    assign rvalid = r.rvalid;
    assign rresp = r.rresp;
    assign rdata = r.rdata;
    assign pwm_out = r.pwm_q;
    assign int_n = r.int_n;
    assign trig_oe = r.trig_oe;
    assign trig_out = r.trig_out;

endmodule : lse_engine

`default_nettype wire

// ### sim/lse_engine_sva.sv
// concurrent checks on the led sequence engine ports
`timescale 1ns/1ps
`default_nettype none
`include "lse_params.svh"
module lse_chk #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              sys_rst,
    // register bus
    input wire logic              awvalid,
    input wire logic              awready,
    input wire logic              wvalid,
    input wire logic              wready,
    input wire logic              bvalid,
    input wire logic              bready,
    input wire logic [1:0]        bresp,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic              rvalid,
    input wire logic              rready,
    input wire logic [31:0]       rdata,
    input wire logic [1:0]        rresp,
    // pins
    input wire logic              trig_out,
    input wire logic [2:0][7:0]   pwm_out,
    input wire logic              int_n
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    aw_block_a: assert property (awvalid && awready |=> !awready)
        else $error("write address accepted twice");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    r_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    b_answer_a: assert property (
        awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
        else $error("write answer late");
    slverr_a: assert property (arvalid && arready
        && araddr[9:2] > `LSE_IX_PMEM_END
        |=> rresp == `LSE_RESP_ERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    pin_low_a: assert property (trig_out == 1'b0)
        else $error("trigger pin driven high");
    int_rel_a: assert property (
        $rose(int_n) |-> rvalid || $past(rvalid) || $past(rvalid, 2))
        else $error("interrupt released without status read");
    pwm_tick_a: assert property (
        $changed(pwm_out) |=> $stable(pwm_out) [*3])
        else $error("pwm changed off the timebase");
endmodule : lse_chk
bind lse_engine lse_chk #(.ADDR_W(ADDR_W)) u_chk (
    .clk, .sys_rst, .awvalid, .awready, .wvalid, .wready, .bvalid,
    .bready, .bresp, .araddr, .arvalid, .arready, .rvalid, .rready,
    .rdata, .rresp, .trig_out, .pwm_out, .int_n
);
`default_nettype wire

// ### sim/lse_pin_model.sv
// timebase source and trigger pin of the far side
`timescale 1ns/1ps
`default_nettype none
module lse_pin_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // trigger pin parties
    input  wire logic trig_oe,
    input  wire logic trig_out,
    input  wire logic ext_pull,
    // timebase and pin level
    output logic      slow_clock_input,
    output logic      trig_in_n
);
    logic [1:0] div;
    // one timebase period every eight clocks
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div <= 2'h0;
            slow_clock_input <= 1'b0;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3) slow_clock_input <= ~slow_clock_input;
        end
    end
    // pulled up, low while any party pulls
    assign trig_in_n = ~((trig_oe && !trig_out) || ext_pull);
endmodule : lse_pin_model
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the led sequence engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic            clk = 1'b0;
    logic            sys_rst = 1'b1;
    logic            ce = 1'b1;
    logic [11:0]     awaddr = 12'h000;
    logic [11:0]     araddr = 12'h000;
    logic [31:0]     wdata = 32'h0;
    logic [3:0]      wstrb = 4'hF;
    logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic            arvalid = 1'b0, rready = 1'b0, ext_pull = 1'b0;
    logic            awready, wready, bvalid, arready, rvalid, int_n;
    logic            slow_clock_input, trig_in_n, trig_out, trig_oe;
    logic [1:0]      bresp, rresp;
    logic [31:0]     rdata, d;
    logic [2:0][7:0] pwm_out;
    logic [2:0]      seen;
    logic [1:0]      rresp_q;
    int              err_total = 0, comparisons = 0, oe_cnt = 0;
    // words 0..3 of red, green, blue: first run, then trigger run
    localparam logic [15:0] PROG [24] = '{
        16'h4010, 16'h0103, 16'hD800, 16'h0000,
        16'h4000, 16'h0101, 16'hA101, 16'hD000,
        16'h40FE, 16'h0103, 16'hD000, 16'h0000,
        16'hE044, 16'hC000, 16'h0000, 16'h0000,
        16'hE080, 16'h405A, 16'hD000, 16'h0000,
        16'hF000, 16'h4033, 16'hD000, 16'h0000};
    always #25 clk = ~clk;
    lse_engine DUT (.clk, .sys_rst, .ce, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .slow_clock_input, .trig_in_n, .trig_out, .trig_oe, .pwm_out,
        .int_n);
    lse_pin_model u_pins (.clk, .sys_rst, .trig_oe, .trig_out, .ext_pull,
        .slow_clock_input, .trig_in_n);
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] ix, input logic [7:0] v, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= {2'b00, ix, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (awready) ad = 1'b1;
            if (wready) wd = 1'b1;
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        chk(bresp, er);
    endtask : wr
    task rd(input logic [7:0] ix, output logic [31:0] v);
        araddr <= {2'b00, ix, 2'b00};
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        v = rdata;
        rresp_q = rresp;
        rready <= 1'b0;
    endtask : rd
    task load(input int base);
        for (int i = 0; i < 12; i++) begin
            wr(8'h10 + 8'(i / 4) * 8'h20 + 8'(i % 4) * 8'h02,
                PROG[base + i][15:8], 2'b00);
            wr(8'h11 + 8'(i / 4) * 8'h20 + 8'(i % 4) * 8'h02,
                PROG[base + i][7:0], 2'b00);
        end
    endtask : load
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(8'h00, d);
        chk(d, 32'h0);
        rd(8'h2E, d);
        chk(d, 32'h0);
        rd(8'h0D, d);
        chk(d, 32'h0);
        chk(rresp_q, 2'b10);
        rd(8'h70, d);
        chk(rresp_q, 2'b10);
        wr(8'h0E, 8'h55, 2'b10);
        $display("test reset done");
        wr(8'h08, 8'h02, 2'b00);
        load(0);
        wr(8'h00, 8'h2A, 2'b00);
        seen = 3'h0;
        for (int k = 0; k < 200 && seen != 3'h7; k++) begin
            repeat (50) @(posedge clk);
            rd(8'h0C, d);
            seen = seen | d[2:0];
        end
        chk(seen, 3'h7);
        chk(pwm_out[0], 8'h00);
        chk(pwm_out[1], 8'(3 * 2));
        chk(pwm_out[2], 8'hFF);
        repeat (3) @(posedge clk);
        chk(int_n, 1'b1);
        rd(8'h0C, d);
        chk(d[3:0], 4'h8);
        rd(8'h00, d);
        chk(d, 32'h0);
        for (int c = 0; c < 3; c++) begin
            rd(8'h09 + 8'(c), d);
            chk(d, 32'h0);
        end
        $display("test run done");
        wr(8'h00, 8'h80, 2'b00);
        repeat (20) @(posedge clk);
        chk(pwm_out[1], 8'h00);
        chk(pwm_out[2], 8'hFF);
        $display("test log done");
        // red sends to green and the pin, blue waits for the pin
        load(12);
        wr(8'h00, 8'h2A, 2'b00);
        repeat (240) begin
            @(posedge clk);
            oe_cnt += int'(trig_oe);
        end
        chk(oe_cnt, 3 * 8);
        chk(pwm_out[1], 8'h5A);
        chk(pwm_out[2], 8'hFF);
        // pin pulse while frozen must be missed
        ce <= 1'b0;
        ext_pull <= 1'b1;
        repeat (40) @(posedge clk);
        ext_pull <= 1'b0;
        ce <= 1'b1;
        repeat (40) @(posedge clk);
        chk(pwm_out[2], 8'hFF);
        ext_pull <= 1'b1;
        repeat (40) @(posedge clk);
        ext_pull <= 1'b0;
        repeat (400) @(posedge clk);
        chk(pwm_out[2], 8'h33);
        chk(int_n, 1'b0);
        rd(8'h0C, d);
        chk(d, 32'h0B);
        $display("test trigger done");
        wr(8'h00, 8'h10, 2'b00);
        repeat (240) @(posedge clk);
        rd(8'h09, d);
        chk(d, 32'h1);
        rd(8'h00, d);
        chk(d, 32'h0);
        $display("test step done");
        tally_and_finish();
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
